// ### rtl/bfp_pickup.sv
// Breaker failure pick-up and blocking stage with Avalon-MM register slave
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`include "bfp_defines.svh"
module bfp_pickup #(
  parameter int CYCLE_CLKS = `BFP_CYCLE_CLKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire bfp_pkg::bfp_meas_t meas,
  input wire logic do_monitor,
  input wire logic signal_monitor,
  input wire logic blocking_in,
  input wire logic retrip_active,
  input wire logic failure_active,
  output logic start_out,
  output logic retrip_out,
  output logic breaker_failure_output,
  output logic blocked_out,
  output logic block_event
);

  bfp_pkg::bfp_state_t st_ff;
  bfp_pkg::bfp_state_t nxt_st;

  // Per-channel magnitudes; residual follows the source selector
  logic [3:0][15:0] ch_mag;
  logic [3:0] pu_nxt;
  logic tick;
  logic cur_pu;
  logic pickup;
  logic blk_src;

  assign ch_mag[0] = meas.l1;
  assign ch_mag[1] = meas.l2;
  assign ch_mag[2] = meas.l3;
  assign ch_mag[3] = (st_ff.res_sel == 2'h1) ? meas.res_one :
                     (st_ff.res_sel == 2'h2) ? meas.res_two : meas.res_calc;

  // Comparator with built-in reset ratio, one per channel
  for (genvar gi = 0; gi < 4; gi++) begin : g_ch
    logic [15:0] thr;
    logic en;
    logic [23:0] mag_pct;
    logic [23:0] thr_pct;
    assign thr = (gi == 3) ? st_ff.res_thr : st_ff.phase_thr;
    assign en = (gi == 3) ? (st_ff.res_sel != 2'h0) : 1'b1;
    assign mag_pct = 24'(ch_mag[gi]) * `BFP_FULL_PCT;
    assign thr_pct = 24'(thr) * `BFP_HYST_PCT;
    assign pu_nxt[gi] = en & (st_ff.pu[gi] ? !(mag_pct < thr_pct) : (ch_mag[gi] > thr));
  end

  // Any phase or residual pick-up counts
  assign cur_pu = |st_ff.pu;
  assign tick = (st_ff.tick_cnt == `BFP_TICK_W'(CYCLE_CLKS - 1));
  assign blk_src = (st_ff.force_en ? st_ff.sw_blk : blocking_in) |
                   (st_ff.ln == bfp_pkg::BFP_LN_BLOCKED) | (st_ff.ln == bfp_pkg::BFP_LN_TEST_BLK);

  // Mode combination of current, output relay and binary signal triggers
  always_comb begin
    case (st_ff.mode)
      bfp_pkg::BFP_M_DO: pickup = do_monitor;
      bfp_pkg::BFP_M_SIG: pickup = signal_monitor;
      bfp_pkg::BFP_M_CUR_AND_DO: pickup = cur_pu & do_monitor;
      bfp_pkg::BFP_M_CUR_OR_DO: pickup = cur_pu | do_monitor;
      bfp_pkg::BFP_M_CUR_AND_SIG: pickup = cur_pu & signal_monitor;
      bfp_pkg::BFP_M_CUR_OR_SIG: pickup = cur_pu | signal_monitor;
      bfp_pkg::BFP_M_SIG_OR_DO: pickup = signal_monitor | do_monitor;
      bfp_pkg::BFP_M_ANY: pickup = cur_pu | do_monitor | signal_monitor;
      bfp_pkg::BFP_M_ALL: pickup = cur_pu & do_monitor & signal_monitor;
      default: pickup = cur_pu;
    endcase
    if (st_ff.ln == bfp_pkg::BFP_LN_OFF) begin
      pickup = 1'b0;
    end
  end

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register read image
  function automatic logic [31:0] rd_word(input bfp_pkg::bfp_state_t s, input logic [5:0] a);
    logic [31:0] w;
    logic [2:0] fs;
    w = 32'h0;
    fs = s.blocked ? bfp_pkg::BFP_FS_BLOCKED : s.fail ? bfp_pkg::BFP_FS_FAIL :
         s.retrip ? bfp_pkg::BFP_FS_RETRIP : s.start ? bfp_pkg::BFP_FS_START : bfp_pkg::BFP_FS_NORMAL;
    case (a)
      `BFP_OFS_CTRL: begin
        w[`BFP_CTRL_RSEL_LSB +: 2] = s.res_sel;
        w[`BFP_CTRL_MODE_LSB +: 4] = s.mode;
        w[`BFP_CTRL_FORCE_BIT] = s.force_en;
        w[`BFP_CTRL_SWBLK_BIT] = s.sw_blk;
        w[`BFP_CTRL_LN_LSB +: 3] = s.ln;
      end
      `BFP_OFS_PHASE_THR: w[15:0] = s.phase_thr;
      `BFP_OFS_RES_THR: w[15:0] = s.res_thr;
      `BFP_OFS_STATUS: begin
        w[`BFP_STAT_FSTATE_LSB +: 3] = fs;
        w[`BFP_STAT_LN_LSB +: 3] = s.ln;
        w[`BFP_STAT_START_BIT] = s.start;
        w[`BFP_STAT_BLOCKED_BIT] = s.blocked;
        w[`BFP_STAT_PICKUP_BIT] = |s.pu;
        w[`BFP_STAT_EVT_BIT] = s.evt_flag;
      end
      `BFP_OFS_FAULT: w[3:0] = s.fault;
      `BFP_OFS_CAP0: w[15:0] = s.cap[0];
      `BFP_OFS_CAP0 + 6'h04: w[15:0] = s.cap[1];
      `BFP_OFS_CAP0 + 6'h08: w[15:0] = s.cap[2];
      `BFP_OFS_CAP0 + 6'h0C: w[15:0] = s.cap[3];
      default: w = 32'h0;
    endcase
    return w;
  endfunction

  // Next-state logic
  always_comb begin
    logic [31:0] wv;
    logic wr_now;
    wv = 32'h0;
    nxt_st = st_ff;
    // Bus handshake: one wait cycle, then answer
    wr_now = avs_write & !st_ff.wait_req;
    if ((avs_read | avs_write) & st_ff.wait_req) begin
      nxt_st.wait_req = 1'b0;
      nxt_st.rdata = avs_read ? rd_word(st_ff, avs_address) : 32'h0;
    end else begin
      nxt_st.wait_req = 1'b1;
    end
    if (wr_now) begin
      wv = merge(rd_word(st_ff, avs_address), avs_writedata, avs_byteenable);
      case (avs_address)
        `BFP_OFS_CTRL: begin
          nxt_st.res_sel = wv[`BFP_CTRL_RSEL_LSB +: 2];
          nxt_st.mode = wv[`BFP_CTRL_MODE_LSB +: 4];
          nxt_st.force_en = wv[`BFP_CTRL_FORCE_BIT];
          nxt_st.sw_blk = wv[`BFP_CTRL_SWBLK_BIT];
          if (wv[`BFP_CTRL_LN_LSB +: 3] >= 3'h1 && wv[`BFP_CTRL_LN_LSB +: 3] <= 3'h5) begin
            nxt_st.ln = bfp_pkg::bfp_ln_t'(wv[`BFP_CTRL_LN_LSB +: 3]);
          end
        end
        `BFP_OFS_PHASE_THR: nxt_st.phase_thr = wv[15:0];
        `BFP_OFS_RES_THR: nxt_st.res_thr = wv[15:0];
        default: nxt_st.mode = st_ff.mode;
      endcase
    end
    // Program cycle divider and blocking sample at its start
    nxt_st.tick_cnt = tick ? `BFP_TICK_W'(0) : st_ff.tick_cnt + `BFP_TICK_W'(1);
    if (tick) begin
      nxt_st.blk = blk_src;
    end
    // Pick-up, start and blocked indications
    nxt_st.pu = pu_nxt;
    nxt_st.start = pickup & !st_ff.blk;
    nxt_st.blocked = pickup & st_ff.blk;
    nxt_st.retrip = retrip_active & nxt_st.start;
    nxt_st.fail = failure_active & nxt_st.start;
    // Blocked entry event with captured currents and fault type
    nxt_st.evt = nxt_st.blocked & !st_ff.blocked;
    if (nxt_st.evt) begin
      nxt_st.cap = ch_mag;
      nxt_st.fault = st_ff.pu;
    end
    // Sticky display flag: write one to clear, a new event wins
    if (wr_now && avs_address == `BFP_OFS_STATUS && avs_byteenable[1] && avs_writedata[`BFP_STAT_EVT_BIT]) begin
      nxt_st.evt_flag = 1'b0;
    end
    if (nxt_st.evt) begin
      nxt_st.evt_flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.wait_req <= 1'b1;
      st_ff.res_sel <= `BFP_RST_RSEL;
      st_ff.mode <= `BFP_RST_MODE;
      st_ff.ln <= bfp_pkg::BFP_LN_ON;
      st_ff.phase_thr <= `BFP_RST_PHASE_THR;
      st_ff.res_thr <= `BFP_RST_RES_THR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;
  assign start_out = st_ff.start;
  assign retrip_out = st_ff.retrip;
  assign breaker_failure_output = st_ff.fail;
  assign blocked_out = st_ff.blocked;
  assign block_event = st_ff.evt;

  // Status word as software sees it; the display checks read it
  logic [31:0] stat_img;
  assign stat_img = rd_word(st_ff, `BFP_OFS_STATUS);

  // Reset ratio limits of phase two and the residual channel, for the drop-out checks
  logic l2_below;
  logic res_below;
  assign l2_below = 24'(meas.l2) * `BFP_FULL_PCT < 24'(st_ff.phase_thr) * `BFP_HYST_PCT;
  assign res_below = 24'(ch_mag[3]) * `BFP_FULL_PCT < 24'(st_ff.res_thr) * `BFP_HYST_PCT;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_block_enter;
    !st_ff.blocked ##1 st_ff.blocked;
  endsequence

  sequence s_event_pulse;
    st_ff.evt ##1 !st_ff.evt;
  endsequence

  a_start_not_blocked: assert property (!(start_out && blocked_out))
    else $error("start and blocked both high");
  a_phase_pickup_rise: assert property (meas.l1 > st_ff.phase_thr && !st_ff.pu[0] |=> st_ff.pu[0])
    else $error("phase one did not pick up");
  a_phase_hyst_hold: assert property (st_ff.pu[1] && !l2_below |=> st_ff.pu[1])
    else $error("phase two dropped above reset ratio");
  a_residual_off: assert property (st_ff.res_sel == 2'h0 |=> !st_ff.pu[3])
    else $error("residual picked up while unused");
  a_signal_no_delay: assert property (st_ff.mode == 4'h2 && st_ff.ln != 3'h5 && signal_monitor && !st_ff.blk
    |=> start_out)
    else $error("signal pick-up did not start at once");
  a_bad_mode_cur: assert property (st_ff.mode == 4'h8 && st_ff.ln != 3'h5 && |st_ff.pu && !st_ff.blk
    && !do_monitor |=> start_out)
    else $error("unused mode not treated as current");
  a_block_clears_start: assert property (start_out && st_ff.blk |=> !start_out)
    else $error("start survived blocking");
  a_block_sampled: assert property (!tick |=> $stable(st_ff.blk))
    else $error("blocking sampled off cycle start");
  a_block_event_seq: assert property (s_block_enter |-> ##0 s_event_pulse)
    else $error("blocked entry without single event");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  a_bus_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("idle bus answered");

  // Display codes as software reads them
  a_state_blocked: assert property (blocked_out |-> stat_img[2:0] == 3'h4)
    else $error("blocked state not shown");
  a_state_start: assert property (start_out && !retrip_out && !breaker_failure_output
    |-> stat_img[2:0] == 3'h1)
    else $error("start state not shown");
  a_state_normal: assert property (!start_out && !blocked_out |-> stat_img[2:0] == 3'h0)
    else $error("idle state not shown as normal");
  a_ln_code_range: assert property (stat_img[6:4] >= 3'h1 && stat_img[6:4] <= 3'h5)
    else $error("node behaviour code out of range");

  // Drop-out of phase two and the residual channel, rise of the residual channel and the third phase
  a_phase_drop: assert property (st_ff.pu[1] && l2_below |=> !st_ff.pu[1])
    else $error("phase two held below reset ratio");
  a_res_drop: assert property (st_ff.pu[3] && res_below |=> !st_ff.pu[3])
    else $error("residual held below reset ratio");
  a_res_rise: assert property (st_ff.res_sel != 2'h0 && !st_ff.pu[3] && ch_mag[3] > st_ff.res_thr
    |=> st_ff.pu[3])
    else $error("residual did not pick up");
  a_phase_three_rise: assert property (meas.l3 > st_ff.phase_thr && !st_ff.pu[2] |=> st_ff.pu[2])
    else $error("phase three did not pick up");

  // Residual source routing
  a_res_src_one: assert property (st_ff.res_sel == 2'h1 |-> ch_mag[3] == meas.res_one)
    else $error("first residual input not selected");
  a_res_src_two: assert property (st_ff.res_sel == 2'h2 |-> ch_mag[3] == meas.res_two)
    else $error("second residual input not selected");
  a_res_src_calc: assert property (st_ff.res_sel == 2'h3 |-> ch_mag[3] == meas.res_calc)
    else $error("computed residual not selected");

  // A phase pick-up rises only on a magnitude above the threshold
  sequence s_l1_rise;
    !st_ff.pu[0] ##1 st_ff.pu[0];
  endsequence

  a_rise_needs_over: assert property (s_l1_rise |-> $past(meas.l1) > $past(st_ff.phase_thr))
    else $error("phase one picked up at or below threshold");

  // Start and blocked follow the pick-up and the sampled block level
  a_pickup_acts: assert property ((|st_ff.pu) && st_ff.mode == 4'h0 && st_ff.ln != 3'h5
    |=> start_out || blocked_out)
    else $error("current pick-up gave no indication");
  a_start_cause: assert property (start_out |-> $past(pickup) && !$past(st_ff.blk))
    else $error("start without unblocked pick-up");
  a_blocked_cause: assert property (blocked_out |-> $past(pickup) && $past(st_ff.blk))
    else $error("blocked without blocked pick-up");
  a_blocked_quiet: assert property (blocked_out |-> !retrip_out && !breaker_failure_output)
    else $error("action shown while blocked");
  a_action_gated: assert property (retrip_out || breaker_failure_output |-> start_out)
    else $error("action shown without start");

  // Operating mode combinations of the binary triggers
  a_do_only: assert property (st_ff.mode == 4'h1 && st_ff.ln != 3'h5 && do_monitor && !st_ff.blk
    |=> start_out)
    else $error("output relay mode did not start");
  a_and_do: assert property (st_ff.mode == 4'h3 && !do_monitor |=> !start_out && !blocked_out)
    else $error("current and relay mode picked up without relay");
  a_and_all: assert property (st_ff.mode == 4'hA && !signal_monitor |=> !start_out && !blocked_out)
    else $error("all-trigger mode picked up without signal");
  a_any_sig: assert property (st_ff.mode == 4'h9 && st_ff.ln != 3'h5 && signal_monitor && !st_ff.blk
    |=> start_out)
    else $error("any-trigger mode did not start on signal");

  // Node modes and the blocking source
  a_ln_off_quiet: assert property (st_ff.ln == bfp_pkg::BFP_LN_OFF |=> !start_out && !blocked_out)
    else $error("off mode still indicated");
  a_ln_blk_forces: assert property (tick && (st_ff.ln == bfp_pkg::BFP_LN_BLOCKED ||
    st_ff.ln == bfp_pkg::BFP_LN_TEST_BLK) |=> st_ff.blk)
    else $error("blocked node mode did not block");
  a_block_take: assert property (tick |=> st_ff.blk == $past(blk_src))
    else $error("block level not taken at cycle start");
  a_force_source: assert property (tick && st_ff.force_en && st_ff.ln == bfp_pkg::BFP_LN_ON
    |=> st_ff.blk == $past(st_ff.sw_blk))
    else $error("software switch did not drive blocking");
  a_tick_range: assert property (st_ff.tick_cnt <= `BFP_TICK_W'(CYCLE_CLKS - 1))
    else $error("program cycle counter out of range");

  // Blocked entry event contents
  a_event_flag: assert property (block_event |-> st_ff.evt_flag)
    else $error("event without display flag");
  a_event_fault: assert property (block_event |-> st_ff.fault == $past(st_ff.pu))
    else $error("fault type not captured");
  a_event_capture: assert property (block_event |-> st_ff.cap[0] == $past(meas.l1))
    else $error("start current not captured");

endmodule

// ### rtl/bfp_defines.svh
// Offsets, field positions, reset values and timing counts of the breaker failure pick-up block
`ifndef BFP_DEFINES_SVH
`define BFP_DEFINES_SVH

// Register byte offsets
`define BFP_OFS_CTRL 6'h00
`define BFP_OFS_PHASE_THR 6'h04
`define BFP_OFS_RES_THR 6'h08
`define BFP_OFS_STATUS 6'h0C
`define BFP_OFS_FAULT 6'h10
`define BFP_OFS_CAP0 6'h14

// Control register fields
`define BFP_CTRL_RSEL_LSB 0
`define BFP_CTRL_MODE_LSB 4
`define BFP_CTRL_FORCE_BIT 8
`define BFP_CTRL_SWBLK_BIT 9
`define BFP_CTRL_LN_LSB 12

// Status register fields
`define BFP_STAT_FSTATE_LSB 0
`define BFP_STAT_LN_LSB 4
`define BFP_STAT_START_BIT 8
`define BFP_STAT_BLOCKED_BIT 9
`define BFP_STAT_PICKUP_BIT 10
`define BFP_STAT_EVT_BIT 11

// Reset values
`define BFP_RST_RSEL 2'h0
`define BFP_RST_MODE 4'h0
`define BFP_RST_LN 3'h1
`define BFP_RST_PHASE_THR 16'h0014
`define BFP_RST_RES_THR 16'h04B0

// Hysteresis ratio in percent
`define BFP_HYST_PCT 24'h61
`define BFP_FULL_PCT 24'h64

// Program cycle timing
`define BFP_CYCLE_MS 5
`define BFP_CLK_KHZ 200000
`define BFP_CYCLE_CLKS (`BFP_CYCLE_MS * `BFP_CLK_KHZ)
`define BFP_TICK_W 20

`endif

// ### rtl/bfp_pkg.sv
// Types of the breaker failure pick-up block
`include "bfp_defines.svh"
package bfp_pkg;

  // Operating modes
  typedef enum logic [3:0] {
    BFP_M_CUR = 4'h0, BFP_M_DO = 4'h1, BFP_M_SIG = 4'h2, BFP_M_CUR_AND_DO = 4'h3,
    BFP_M_CUR_OR_DO = 4'h4, BFP_M_CUR_AND_SIG = 4'h5, BFP_M_CUR_OR_SIG = 4'h6,
    BFP_M_SIG_OR_DO = 4'h7, BFP_M_ANY = 4'h9, BFP_M_ALL = 4'hA
  } bfp_mode_t;

  // Function state display codes
  typedef enum logic [2:0] {
    BFP_FS_NORMAL = 3'h0, BFP_FS_START = 3'h1, BFP_FS_RETRIP = 3'h2,
    BFP_FS_FAIL = 3'h3, BFP_FS_BLOCKED = 3'h4
  } bfp_fstate_t;

  // Node behaviour codes
  typedef enum logic [2:0] {
    BFP_LN_ON = 3'h1, BFP_LN_BLOCKED = 3'h2, BFP_LN_TEST = 3'h3,
    BFP_LN_TEST_BLK = 3'h4, BFP_LN_OFF = 3'h5
  } bfp_ln_t;

  // Magnitudes from the measurement front end
  typedef struct packed {
    logic [15:0] l1;
    logic [15:0] l2;
    logic [15:0] l3;
    logic [15:0] res_one;
    logic [15:0] res_two;
    logic [15:0] res_calc;
  } bfp_meas_t;

  // Whole state of the block
  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic [1:0] res_sel;
    logic [3:0] mode;
    logic force_en;
    logic sw_blk;
    bfp_ln_t ln;
    logic [15:0] phase_thr;
    logic [15:0] res_thr;
    logic [`BFP_TICK_W-1:0] tick_cnt;
    logic blk;
    logic [3:0] pu;
    logic start;
    logic blocked;
    logic retrip;
    logic fail;
    logic evt;
    logic evt_flag;
    logic [3:0] fault;
    logic [3:0][15:0] cap;
  } bfp_state_t;

endpackage

// ### verif/bfp_front_model.sv
// Measurement front end and blocking matrix model for the pick-up block
module bfp_front_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0][15:0] set_mag,
  input wire logic set_do,
  input wire logic set_sig,
  input wire logic set_blk,
  output bfp_pkg::bfp_meas_t meas,
  output logic do_monitor,
  output logic signal_monitor,
  output logic blocking_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Refresh magnitudes and binary levels on the shared clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meas <= '0;
      do_monitor <= 1'b0;
      signal_monitor <= 1'b0;
      blocking_in <= 1'b0;
    end else begin
      meas <= set_mag;
      do_monitor <= set_do;
      signal_monitor <= set_sig;
      blocking_in <= set_blk;
    end
  end
endmodule

// ### verif/tb_top.sv
// Self-checking bench of the breaker failure pick-up block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic avs_waitrequest, do_m, sig_m, blk_in, set_do = 0, set_sig = 0, set_blk = 0, ret_a = 0, fail_a = 0;
  logic start_out, retrip_out, bf_out, blocked_out, block_event;
  logic [5:0][15:0] mag = '0;
  bfp_pkg::bfp_meas_t meas;
  int mismatches = 0, compares = 0, evts = 0, thr, e;
  // Clock at 200 MHz
  always #2.5 clk_sys = ~clk_sys;
  // Count one-cycle block event pulses
  always @(posedge clk_sys) if (block_event === 1'b1) evts++;
  bfp_front_model i_front (.clk_sys(clk_sys), .rst(rst), .set_mag(mag), .set_do(set_do), .set_sig(set_sig),
    .set_blk(set_blk), .meas(meas), .do_monitor(do_m), .signal_monitor(sig_m), .blocking_in(blk_in));
  bfp_pickup #(.CYCLE_CLKS(8)) i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas(meas), .do_monitor(do_m),
    .signal_monitor(sig_m), .blocking_in(blk_in), .retrip_active(ret_a), .failure_active(fail_a),
    .start_out(start_out), .retrip_out(retrip_out), .breaker_failure_output(bf_out),
    .blocked_out(blocked_out), .block_event(block_event));
  // Verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      finish_test();
    end else begin
      @(posedge clk_sys);
    end
  endtask
  task automatic wctrl(input logic [31:0] v);
    bus(1'b1, 6'h00, v | 32'h0000_1000, rd);
  endtask
  // Expected pick-up of each operating mode
  function automatic logic mode_exp(input int md, input logic c, input logic d, input logic s);
    case (md)
      1: return d;
      2: return s;
      3: return c & d;
      4: return c | d;
      5: return c & s;
      6: return c | s;
      7: return s | d;
      9: return c | d | s;
      10: return c & d & s;
      default: return c;
    endcase
  endfunction
  initial begin
    rd = $urandom(32'h30891DA5);
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    // Reset values and an unmapped place
    bus(0, 6'h00, 0, rd); check("ctrl", rd, 32'h0000_1000);
    bus(0, 6'h04, 0, rd); check("phase_thr", rd, 32'h0000_0014);
    bus(0, 6'h08, 0, rd); check("res_thr", rd, 32'h0000_04B0);
    bus(0, 6'h0C, 0, rd); check("status", rd, 32'h0000_0010);
    bus(0, 6'h3C, 0, rd); check("unmapped", rd, 32'h0);
    // Each phase against the shared threshold, with hysteresis
    for (int p = 5; p >= 3; p--) begin
      mag <= '0; cyc(4);
      mag[p] <= 16'h0015; cyc(4); check("start_up", start_out, 1);
      mag[p] <= 16'h0014; cyc(4); check("start_hold", start_out, 1);
      mag[p] <= 16'h0013; cyc(4); check("start_drop", start_out, 0);
    end
    // Random thresholds and phase magnitudes
    repeat (24) begin
      thr = 100 + $urandom % 900;
      bus(1, 6'h04, thr, rd);
      mag <= '0; cyc(4);
      e = 0;
      for (int p = 5; p >= 3; p--) begin
        mag[p] <= 16'(thr - 40 + $urandom % 60);
        e = e | (($urandom % 2) == 0);
      end
      cyc(1);
      e = (mag[5] > thr) || (mag[4] > thr) || (mag[3] > thr);
      cyc(4); check("start_rand", start_out, e);
    end
    // Residual source select
    bus(1, 6'h08, 32'h100, rd);
    for (int s = 0; s < 4; s++) begin
      wctrl(s);
      for (int k = 0; k < 3; k++) begin
        mag <= '0; cyc(4);
        mag[2-k] <= 16'h0101; cyc(4);
        check("start_res", start_out, s != 0 && s - 1 == k);
      end
    end
    // Every operating mode code with every trigger combination
    bus(1, 6'h04, 32'h14, rd);
    for (int md = 0; md < 16; md++) begin
      wctrl(md << 4);
      for (int c = 0; c < 8; c++) begin
        mag <= '0; set_do <= 0; set_sig <= 0; cyc(4);
        mag[5] <= c[0] ? 16'h0015 : 16'h0; set_do <= c[1]; set_sig <= c[2]; cyc(4);
        check("start_mode", start_out, mode_exp(md, c[0], c[1], c[2]));
      end
    end
    // Pick-up while blocked, release, then block after start
    wctrl(0); mag <= '0; set_do <= 0; set_sig <= 0; set_blk <= 1; evts = 0; cyc(20);
    mag[5] <= 16'h0015; cyc(4);
    check("blocked", {start_out, blocked_out}, 2'b01);
    bus(0, 6'h0C, 0, rd); check("status_blk", rd, 32'h0000_0E14);
    bus(0, 6'h10, 0, rd); check("fault", rd, 32'h1);
    bus(0, 6'h14, 0, rd); check("cap_l1", rd, 32'h15);
    bus(0, 6'h20, 0, rd); check("cap_res", rd, 32'h0);
    bus(1, 6'h0C, 32'h800, rd); bus(0, 6'h0C, 0, rd); check("evt_clear", rd, 32'h0000_0614);
    check("evt_count", evts, 1);
    set_blk <= 0; cyc(20); check("unblock", {start_out, blocked_out}, 2'b10);
    ret_a <= 1; fail_a <= 1; cyc(3); check("ret_fail", {retrip_out, bf_out}, 2'b11);
    bus(0, 6'h0C, 0, rd); check("status_fail", rd[2:0], 3'h3);
    set_blk <= 1; cyc(20); check("late_blk", {start_out, retrip_out, blocked_out}, 3'b001);
    check("evt_count2", evts, 2);
    // Software switch drives blocking under stage forcing
    set_blk <= 0; wctrl(32'h0300); cyc(20); check("force_blk", {start_out, blocked_out}, 2'b01);
    wctrl(32'h0100); cyc(20); check("force_rel", {start_out, blocked_out}, 2'b10);
    // Node modes off, blocked, test and test-blocked, and an invalid code ignored
    bus(1, 6'h00, 32'h5000, rd); cyc(20); check("ln_off", start_out, 0);
    bus(0, 6'h0C, 0, rd); check("ln_disp", rd[6:4], 3'h5);
    bus(1, 6'h00, 32'h2000, rd); cyc(20); check("ln_blk", blocked_out, 1);
    bus(1, 6'h00, 32'h3000, rd); cyc(20); check("ln_test", {start_out, blocked_out}, 2'b10);
    bus(1, 6'h00, 32'h4000, rd); cyc(20); check("ln_test_blk", {start_out, blocked_out}, 2'b01);
    bus(1, 6'h00, 32'h7000, rd); bus(0, 6'h00, 0, rd); check("ln_keep", rd[14:12], 3'h4);
    finish_test();
  end
endmodule
